// ===== shared/flash_status_pkg.sv
// Shared constants and types for the flash status and protection block
package flash_status_pkg;

	// ==========================================================
	// Command opcodes
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_READ_SR1 = 8'h05;
	localparam logic [7:0] OP_READ_SR2 = 8'h35;
	localparam logic [7:0] OP_READ_SR3 = 8'h15;
	localparam logic [7:0] OP_WRITE_SR1 = 8'h01;
	localparam logic [7:0] OP_WRITE_SR2 = 8'h31;
	localparam logic [7:0] OP_WRITE_SR3 = 8'h11;
	localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_BLOCK_ERASE_32 = 8'h52;
	localparam logic [7:0] OP_BLOCK_ERASE_64 = 8'hD8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
	localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
	localparam logic [7:0] OP_RESET = 8'h99;

	// ==========================================================
	// Frame byte counts (opcode included)
	localparam logic [2:0] LEN_PLAIN = 3'h1;
	localparam logic [2:0] LEN_SR_WRITE = 3'h2;
	localparam logic [2:0] LEN_ERASE = 3'h4;
	localparam logic [2:0] LEN_PROGRAM = 3'h5;
	localparam logic [2:0] BYTE_CNT_MAX = 3'h7;
	localparam logic [2:0] LAST_BIT = 3'h7;

	// ==========================================================
	// Reset values and timing
	localparam logic [1:0] DRIVE_RESET = 2'h1;
	localparam logic [1:0] LOCK_SOFTWARE = 2'h0;
	localparam logic [1:0] LOCK_HARDWARE = 2'h1;
	localparam logic [15:0] BUSY_CYCLES_DEFAULT = 16'h03E8;

	// ==========================================================
	// Array geometry (4 MB, 22 address bits)
	localparam int ADDR_W = 22;
	localparam logic [22:0] ARRAY_SIZE = 23'h40_0000;
	localparam logic [22:0] BLOCK_SIZE = 23'h01_0000;
	localparam logic [22:0] SECTOR_SIZE = 23'h00_1000;
	localparam logic [2:0] CODE_NONE = 3'h0;
	localparam logic [2:0] CODE_ALL = 3'h7;
	localparam logic [2:0] CODE_SMALL_CAP = 3'h3;

	typedef enum logic [1:0] {
		OPK_PROGRAM = 2'b00,
		OPK_SECTOR = 2'b01,
		OPK_BLOCK = 2'b10,
		OPK_CHIP = 2'b11
	} op_kind_e;

	typedef struct packed {
		op_kind_e kind;
		logic [23:0] addr;
	} array_op_s;

	typedef struct packed {
		logic [1:0] drive_sel;
		logic performance_flag;
		logic erase_suspend_flag;
		logic invert_bit;
		logic [2:0] otp_lock;
		logic program_suspend_flag;
		logic quad_enable_bit;
		logic lock_mode_hi;
		logic lock_mode_lo;
		logic [4:0] protect_field;
		logic write_latch_flag;
		logic busy_flag;
	} status_s;

	// Place the fields at their bit positions, spare bits zero
	function automatic logic [23:0] pack_status(input status_s s);
		pack_status = {1'b0, s.drive_sel, s.performance_flag, 4'h0,
			s.erase_suspend_flag, s.invert_bit, s.otp_lock,
			s.program_suspend_flag, s.quad_enable_bit, s.lock_mode_hi,
			s.lock_mode_lo, s.protect_field, s.write_latch_flag,
			s.busy_flag};
	endfunction

endpackage

// ===== design/protect_region_decoder.sv
// Decoder from protect code and invert bit to a refusal for one address
`timescale 1ns/1ps
`default_nettype none

module protect_region_decoder (
	// Protection setting
	input wire logic [4:0] protect_field,
	input wire logic invert_bit,
	// Address under test
	input wire logic [flash_status_pkg::ADDR_W-1:0] addr,
	// Verdicts
	output logic addr_protected,
	output logic chip_erase_ok
);
	import flash_status_pkg::*;

	logic [2:0] low;
	logic [22:0] span;
	logic [22:0] addr_ext;
	logic base_hit;

	always_comb begin
		low = protect_field[2:0];
		addr_ext = {1'b0, addr};
		span = '0;
		base_hit = 1'b0;
		// R15: plain regions
		if (low == CODE_ALL) begin
			base_hit = 1'b1;
		end else if (low != CODE_NONE) begin
			if (protect_field[4]) begin
				// Codes 4..6 all cap at the 32 KB span
				if (low > CODE_SMALL_CAP) begin
					span = SECTOR_SIZE << 3;
				end else begin
					span = SECTOR_SIZE << (low - 3'h1);
				end
			end else begin
				span = BLOCK_SIZE << (low - 3'h1);
			end
			if (protect_field[3]) begin
				base_hit = addr_ext < span;
			end else begin
				base_hit = addr_ext >= (ARRAY_SIZE - span);
			end
		end
		// R8: invert gives the complement
		addr_protected = base_hit ^ invert_bit;
		// R7: chip erase gate
		chip_erase_ok = (low == CODE_NONE && !invert_bit) ||
			(low == CODE_ALL && invert_bit);
	end

endmodule
`default_nettype wire

// ===== design/flash_status_write_protect.sv
// Status register, write latch and write protection of a serial flash
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1: 24-bit status word in three bytes
// R2: busy reads 1 during program, erase, write
// R3: write latch mirrored; clear latch refuses writes
// R4: protect field changes only by status write
// R5: protected addresses refuse program and erase
// R6: protect field unwritable when hardware protected
// R7: chip erase only for all-zero or all-one codes
// R8: invert bit complements the protected region
// R9: lock mode 00 accepts writes with latch
// R10: lock mode 01 follows write-protect pin
// R11: lock mode 10 refuses until power cycle
// R12: power cycle returns lock mode 10 to 00
// R13: lock mode 11 refuses writes forever; here power-on reset returns it to 00 like mode 10
// R14: lock bits readable, writable, select method
// R15: plain protect codes select top/bottom regions
// R16: invert bit defaults to zero
// R17: latch set by enable, cleared by writes
// R18: reserved bits read zero, ignore writes
module flash_status_write_protect #(
	parameter logic [15:0] BUSY_CYCLES =
		flash_status_pkg::BUSY_CYCLES_DEFAULT
) (
	// Clock and power-on reset
	input wire logic clock,
	input wire logic rst_n,
	// Serial link pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic si,
	input wire logic wp_n,
	output logic so,
	output logic so_oe,
	// Array operation request
	output logic op_start,
	output flash_status_pkg::array_op_s op,
	// Status view
	output flash_status_pkg::status_s status
);
	import flash_status_pkg::*;

	// ==========================================================
	// Pin synchronisers: sclk, cs_n, si, wp_n
	logic [3:0] s1_reg, s2_reg, s3_reg, filt_reg;
	logic [3:0] s1_next, s2_next, s3_next, filt_next;

	always_comb begin
		s1_next = {wp_n, si, cs_n, sclk};
		s2_next = s1_reg;
		s3_next = s2_reg;
		// A change counts once stages two and three agree
		filt_next = (~(s2_reg ^ s3_reg) & s3_reg) |
			((s2_reg ^ s3_reg) & filt_reg);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= 4'hF;
			s2_reg <= 4'hF;
			s3_reg <= 4'hF;
			filt_reg <= 4'hF;
		end else begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			s3_reg <= s3_next;
			filt_reg <= filt_next;
		end
	end

	logic sclk_rise, sclk_fall, cs_fall, cs_rise, frame_on, wp_high;
	assign sclk_rise = !filt_reg[0] && filt_next[0];
	assign sclk_fall = filt_reg[0] && !filt_next[0];
	assign cs_fall = filt_reg[1] && !filt_next[1];
	assign cs_rise = !filt_reg[1] && filt_next[1];
	assign frame_on = !filt_reg[1];
	assign wp_high = filt_reg[3];

	// ==========================================================
	// Helpers
	function automatic logic is_read(input logic [7:0] code);
		is_read = code == OP_READ_SR1 || code == OP_READ_SR2 ||
			code == OP_READ_SR3;
	endfunction

	function automatic logic [7:0] status_byte(input logic [7:0] code,
		input status_s s);
		logic [23:0] w;
		w = pack_status(s);
		unique case (code)
			OP_READ_SR2: status_byte = w[15:8];
			OP_READ_SR3: status_byte = w[23:16];
			default: status_byte = w[7:0];
		endcase
	endfunction

	// ==========================================================
	// Protection decode
	logic [23:0] addr_reg;
	status_s st_reg;
	logic prot_hit, chip_ok;

	protect_region_decoder u_decoder (
		.protect_field(st_reg.protect_field),
		.invert_bit(st_reg.invert_bit),
		.addr(addr_reg[ADDR_W-1:0]),
		.addr_protected(prot_hit),
		.chip_erase_ok(chip_ok)
	);

	// ==========================================================
	// Command capture and execution
	logic [2:0] bit_cnt_reg, bit_cnt_next, byte_cnt_reg, byte_cnt_next;
	logic [2:0] fall_cnt_reg, fall_cnt_next;
	logic [7:0] shift_reg, shift_next, opcode_reg, opcode_next;
	logic [7:0] data_reg, data_next, tx_reg, tx_next;
	logic [23:0] addr_next;
	logic [15:0] busy_cnt_reg, busy_cnt_next;
	logic reading_reg, reading_next, arm_reg, arm_next;
	logic so_reg, so_next, so_oe_reg, so_oe_next;
	logic op_start_reg, op_start_next;
	array_op_s op_reg, op_next;
	status_s st_next;
	logic [7:0] byte_in, out_byte;
	logic [1:0] lock_mode;
	logic sr_ok, start_busy, array_req;
	op_kind_e req_kind;

	always_comb begin
		bit_cnt_next = bit_cnt_reg;
		byte_cnt_next = byte_cnt_reg;
		fall_cnt_next = fall_cnt_reg;
		shift_next = shift_reg;
		opcode_next = opcode_reg;
		data_next = data_reg;
		tx_next = tx_reg;
		addr_next = addr_reg;
		reading_next = reading_reg;
		arm_next = arm_reg;
		so_next = so_reg;
		st_next = st_reg;
		op_start_next = 1'b0;
		op_next = op_reg;
		start_busy = 1'b0;
		array_req = 1'b0;
		req_kind = OPK_PROGRAM;
		byte_in = {shift_reg[6:0], filt_next[2]};
		out_byte = tx_reg;
		lock_mode = {st_reg.lock_mode_hi, st_reg.lock_mode_lo};
		// R14: lock mode selects the write gate
		// R9: software mode needs only the latch
		// R10: hardware mode also needs the pin high
		// R11: modes 10 and 11 refuse every status write
		// R13: mode 11 is left only by power-on reset, as mode 10
		sr_ok = st_reg.write_latch_flag &&
			(lock_mode == LOCK_SOFTWARE ||
			(lock_mode == LOCK_HARDWARE && wp_high));

		if (cs_fall) begin
			bit_cnt_next = '0;
			byte_cnt_next = '0;
			reading_next = 1'b0;
		end else if (frame_on && sclk_rise) begin
			bit_cnt_next = bit_cnt_reg + 3'h1;
			shift_next = byte_in;
			if (bit_cnt_reg == LAST_BIT) begin
				if (byte_cnt_reg == '0) begin
					opcode_next = byte_in;
					reading_next = is_read(byte_in);
					fall_cnt_next = '0;
				end
				if (byte_cnt_reg == LEN_PLAIN) begin
					data_next = byte_in;
				end
				if (byte_cnt_reg >= LEN_PLAIN && byte_cnt_reg < LEN_ERASE) begin
					addr_next = {addr_reg[15:0], byte_in};
				end
				if (byte_cnt_reg != BYTE_CNT_MAX) begin
					byte_cnt_next = byte_cnt_reg + 3'h1;
				end
			end
		end

		// Status bytes repeat while the clock keeps running
		if (frame_on && sclk_fall && reading_reg) begin
			if (fall_cnt_reg == '0) begin
				out_byte = status_byte(opcode_reg, st_reg);
			end
			so_next = out_byte[7];
			tx_next = {out_byte[6:0], 1'b0};
			fall_cnt_next = fall_cnt_reg + 3'h1;
		end

		// Partial last byte rejects the whole frame
		if (cs_rise) begin
			reading_next = 1'b0;
			if (bit_cnt_reg == '0 && !st_reg.busy_flag) begin
				arm_next = 1'b0;
				unique case (opcode_reg)
					OP_WRITE_ENABLE: begin
						// R17: enable sets the latch
						if (byte_cnt_reg == LEN_PLAIN) begin
							st_next.write_latch_flag = 1'b1;
						end
					end
					OP_WRITE_DISABLE: begin
						// R17: disable clears the latch
						if (byte_cnt_reg == LEN_PLAIN) begin
							st_next.write_latch_flag = 1'b0;
						end
					end
					OP_RESET_ENABLE: begin
						arm_next = byte_cnt_reg == LEN_PLAIN;
					end
					OP_RESET: begin
						// R17: software reset clears the latch
						if (arm_reg && byte_cnt_reg == LEN_PLAIN) begin
							st_next.write_latch_flag = 1'b0;
						end
					end
					OP_WRITE_SR1, OP_WRITE_SR2, OP_WRITE_SR3: begin
						// R3: no latch, no write
						if (byte_cnt_reg >= LEN_SR_WRITE &&
							st_reg.write_latch_flag) begin
							// R17: status write clears the latch
							st_next.write_latch_flag = 1'b0;
							// R6: hardware lock blocks the field
							if (sr_ok) begin
								start_busy = 1'b1;
								// R4: protect field set only here
								// R18: spare and read-only bits ignored
								if (opcode_reg == OP_WRITE_SR1) begin
									st_next.protect_field = data_reg[6:2];
									st_next.lock_mode_lo = data_reg[7];
								end else if (opcode_reg == OP_WRITE_SR2) begin
									st_next.lock_mode_hi = data_reg[0];
									st_next.quad_enable_bit = data_reg[1];
									// One-time bits only ever set
									st_next.otp_lock = st_reg.otp_lock | data_reg[5:3];
									st_next.invert_bit = data_reg[6];
								end else begin
									st_next.drive_sel = data_reg[6:5];
								end
							end
						end
					end
					OP_PAGE_PROGRAM: begin
						array_req = byte_cnt_reg >= LEN_PROGRAM;
						req_kind = OPK_PROGRAM;
					end
					OP_SECTOR_ERASE: begin
						array_req = byte_cnt_reg == LEN_ERASE;
						req_kind = OPK_SECTOR;
					end
					OP_BLOCK_ERASE_32, OP_BLOCK_ERASE_64: begin
						array_req = byte_cnt_reg == LEN_ERASE;
						req_kind = OPK_BLOCK;
					end
					OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
						array_req = byte_cnt_reg == LEN_PLAIN;
						req_kind = OPK_CHIP;
					end
					default: begin
					end
				endcase
				// R3: array commands need the latch
				if (array_req && st_reg.write_latch_flag) begin
					// R17: program and erase clear the latch
					st_next.write_latch_flag = 1'b0;
					// R5: protected address refused
					// R7: chip erase only for clear codes
					if ((req_kind == OPK_CHIP) ? chip_ok : !prot_hit) begin
						start_busy = 1'b1;
						op_start_next = 1'b1;
						op_next.kind = req_kind;
						op_next.addr = addr_reg;
					end
				end
			end
		end

		// R2: busy follows the running operation
		if (start_busy) begin
			busy_cnt_next = BUSY_CYCLES;
		end else if (busy_cnt_reg != '0) begin
			busy_cnt_next = busy_cnt_reg - 16'h0001;
		end else begin
			busy_cnt_next = busy_cnt_reg;
		end
		st_next.busy_flag = busy_cnt_next != '0;
		so_oe_next = reading_next && !filt_next[1];
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt_reg <= '0;
			byte_cnt_reg <= '0;
			fall_cnt_reg <= '0;
			shift_reg <= '0;
			opcode_reg <= '0;
			data_reg <= '0;
			tx_reg <= '0;
			addr_reg <= '0;
			reading_reg <= 1'b0;
			arm_reg <= 1'b0;
			so_reg <= 1'b0;
			so_oe_reg <= 1'b0;
			op_start_reg <= 1'b0;
			op_reg <= '{kind: OPK_PROGRAM, addr: 24'h00_0000};
			busy_cnt_reg <= '0;
			// R12: power cycle drops any lock mode
			// R16: invert bit starts clear
			st_reg <= '{drive_sel: DRIVE_RESET, default: '0};
		end else begin
			bit_cnt_reg <= bit_cnt_next;
			byte_cnt_reg <= byte_cnt_next;
			fall_cnt_reg <= fall_cnt_next;
			shift_reg <= shift_next;
			opcode_reg <= opcode_next;
			data_reg <= data_next;
			tx_reg <= tx_next;
			addr_reg <= addr_next;
			reading_reg <= reading_next;
			arm_reg <= arm_next;
			so_reg <= so_next;
			so_oe_reg <= so_oe_next;
			op_start_reg <= op_start_next;
			op_reg <= op_next;
			busy_cnt_reg <= busy_cnt_next;
			st_reg <= st_next;
		end
	end

	assign so = so_reg;
	assign so_oe = so_oe_reg;
	assign op_start = op_start_reg;
	assign op = op_reg;
	// R1: fields held at their documented places
	assign status = st_reg;

	// ==========================================================
	// Checks
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	AST_LATCH_GATE: assert property ( // R3
		op_start_reg |-> $past(st_reg.write_latch_flag))
		else $error("array operation started without write latch");
	AST_LATCH_CLEAR: assert property ( // R17
		op_start_reg |-> !st_reg.write_latch_flag)
		else $error("write latch not cleared by array operation");
	AST_BUSY_HOLD: assert property ( // R2
		op_start_reg |-> st_reg.busy_flag [*8])
		else $error("busy flag dropped too early");
	AST_PROT_REFUSE: assert property ( // R5
		op_start_reg && op_reg.kind != OPK_CHIP |-> !$past(prot_hit))
		else $error("protected address programmed or erased");
	AST_CHIP_GATE: assert property ( // R7
		op_start_reg && op_reg.kind == OPK_CHIP |-> $past(chip_ok))
		else $error("chip erase started with protection set");
	AST_HW_LOCK: assert property ( // R10
		!st_reg.lock_mode_hi && st_reg.lock_mode_lo && !wp_high |=>
		$stable(st_reg.protect_field) && $stable(st_reg.invert_bit))
		else $error("status written while pin low");
	AST_POWER_LOCK: assert property ( // R11
		st_reg.lock_mode_hi |=> st_reg.lock_mode_hi &&
		$stable(st_reg.protect_field) && $stable(st_reg.lock_mode_lo))
		else $error("status changed under power or one-time lock");
	AST_FIELD_WRITE: assert property ( // R4
		!$stable(st_reg.protect_field) |->
		$past(cs_rise) && $past(opcode_reg) == OP_WRITE_SR1)
		else $error("protect field changed outside status write");
	AST_WRITE_BUSY: assert property ( // R2
		!$stable(st_reg.protect_field) |-> st_reg.busy_flag)
		else $error("status write without busy");

endmodule
`default_nettype wire

// ===== verif/spi_host_model.sv
// Host side of the serial link: frames commands and samples replies
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
	// Alignment clock
	input wire logic clock,
	// Link pins
	output var logic sclk,
	output var logic cs_n,
	output var logic si,
	input wire logic so
);
	// ==========================================================
	// Frame transfer, mode 3
	// Clock idles high and stands still between frames
	task automatic xfer(input logic [39:0] tx, input int nbits,
		output logic [7:0] rx);
		@(posedge clock);
		#1 cs_n = 1'b0;
		#16;
		for (int i = 0; i < nbits; i++) begin
			sclk = 1'b0;
			si = tx[39 - i];
			#16 sclk = 1'b1;
			// Reply bit settles late after the fall, so sample mid-high
			#8 rx = {rx[6:0], so};
			#8;
		end
		cs_n = 1'b1;
		// Released line shows the inverse, never a held value
		si = ~si;
		#48;
	endtask

	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		si = 1'b0;
	end
endmodule

`default_nettype wire

// ===== verif/flash_status_write_protect_bench.sv
// Self-checking bench for the flash status and protection block
`timescale 1ns/1ps
`default_nettype none

module flash_status_write_protect_bench;
	import flash_status_pkg::*;

	// ==========================================================
	// Signals and bench state
	// Short busy time keeps the run small
	localparam logic [15:0] BUSY_N = 16'h0010;
	// Reply drive per 16-bit read: eight bit times of eight clocks plus gap
	localparam int OE_READ = 68;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic wp_n = 1'b1;
	logic sclk, cs_n, si, so, so_oe, op_start;
	array_op_s op;
	status_s status;
	int err_count = 0;
	int num_checks = 0;
	int starts = 0;
	int oe_cycles = 0;
	int cycles = 0;
	int seed = 26;
	logic [7:0] rx;
	logic [7:0] opc [4] = '{OP_SECTOR_ERASE, OP_BLOCK_ERASE_32,
		OP_BLOCK_ERASE_64, OP_PAGE_PROGRAM};
	op_kind_e kinds [4] = '{OPK_SECTOR, OPK_BLOCK, OPK_BLOCK, OPK_PROGRAM};
	int lens [4] = '{32, 32, 32, 40};

	always #2 clock = ~clock;

	flash_status_write_protect #(.BUSY_CYCLES(BUSY_N))
		flash_status_write_protect_i (
		.clock(clock), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si),
		.wp_n(wp_n), .so(so), .so_oe(so_oe), .op_start(op_start), .op(op),
		.status(status));

	spi_host_model host_i (.clock(clock), .sclk(sclk), .cs_n(cs_n),
		.si(si), .so(so));

	// ==========================================================
	// Closing, timeout and start counting
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (op_start === 1'b1)
			starts++;
		// Cycles with the reply line driven
		if (so_oe === 1'b1)
			oe_cycles++;
		if (cycles == 60000) begin
			err_count++;
			test_done();
		end
	end

	// ==========================================================
	// Comparison, link and expectation helpers
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic send(input logic [39:0] tx, input int nb);
		host_i.xfer(tx, nb, rx);
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		while (status.busy_flag !== 1'b0 && n < 200) begin
			@(posedge clock);
			#1;
			n++;
		end
		check("busy clears", n < 200, 1);
	endtask

	task automatic wsr(input logic [7:0] op8, input logic [7:0] d,
		input logic acc);
		send({OP_WRITE_ENABLE, 32'h0}, 8);
		send({op8, d, 24'h0}, 16);
		check("sr write busy", status.busy_flag, acc);
		check("latch after sr write", status.write_latch_flag, 0);
		wait_idle();
	endtask

	task automatic rst();
		@(posedge clock);
		#1 rst_n = 1'b0;
		repeat (2) @(posedge clock);
		#1 rst_n = 1'b1;
		repeat (6) @(posedge clock);
	endtask

	// Protected verdict for one address
	function automatic logic prot(input logic [4:0] bp, input logic inv,
		input logic [21:0] a);
		logic p;
		int n;
		n = 1 << (bp[2:0] - 1);
		if (bp[2:0] == 3'h0)
			p = 1'b0;
		else if (bp[2:0] == 3'h7)
			p = 1'b1;
		else if (!bp[4])
			p = bp[3] ? (a[21:16] < n) : (a[21:16] >= 64 - n);
		else begin
			if (n > 8)
				n = 8;
			p = bp[3] ? (a[21:12] < n) : (a[21:12] >= 1024 - n);
		end
		return p ^ inv;
	endfunction

	// ==========================================================
	// Main sequence
	initial begin
		logic [4:0] bp;
		logic inv;
		logic [21:0] a;
		logic acc;
		int k;
		int s0;
		int oe0;
		repeat (2) @(posedge clock);
		#1 rst_n = 1'b1;
		repeat (6) @(posedge clock);
		check("drive reset", status.drive_sel, DRIVE_RESET);
		check("invert reset", status.invert_bit, 0);
		oe0 = oe_cycles;
		send({OP_READ_SR3, 32'h0}, 16);
		check("sr3 read", rx, 8'h20);
		check("read drive", oe_cycles - oe0, OE_READ);
		send({OP_READ_SR2, 32'h0}, 16);
		check("sr2 read", rx, 8'h00);
		send({OP_WRITE_ENABLE, 32'h0}, 8);
		check("latch set", status.write_latch_flag, 1);
		check("write frame drive", oe_cycles - oe0, 2 * OE_READ);
		check("drive off", so_oe, 0);
		send({OP_READ_SR1, 32'h0}, 16);
		check("sr1 latch", rx, 8'h02);
		// Cut-off frame must not execute nor drop the latch
		send({OP_WRITE_SR1, 8'h08, 24'h0}, 12);
		check("partial frame", status.protect_field, 0);
		check("latch kept", status.write_latch_flag, 1);
		send({OP_WRITE_DISABLE, 32'h0}, 8);
		check("latch clear", status.write_latch_flag, 0);
		send({OP_WRITE_SR1, 8'h08, 24'h0}, 16);
		check("no latch write", status.protect_field, 0);
		// Random protection settings against random and edge addresses
		for (int i = 0; i < 20; i++) begin
			bp = $random(seed);
			inv = $random(seed);
			a = $random(seed);
			k = i % 4;
			if (i < 4)
				a = i[1] ? 22'h3F_FFFF : 22'h00_0000;
			wsr(OP_WRITE_SR1, {1'b0, bp, 2'b00}, 1);
			wsr(OP_WRITE_SR2, {1'b0, inv, 6'h00}, 1);
			check("protect field", status.protect_field, bp);
			check("invert", status.invert_bit, inv);
			acc = !prot(bp, inv, a);
			s0 = starts;
			send({OP_WRITE_ENABLE, 32'h0}, 8);
			send({opc[k], 2'b00, a, 8'h5A}, lens[k]);
			check("array start", starts - s0, acc);
			check("array busy", status.busy_flag, acc);
			check("latch after op", status.write_latch_flag, 0);
			if (acc) begin
				check("op addr", op.addr, {2'b00, a});
				check("op kind", op.kind, kinds[k]);
			end
			wait_idle();
		end
		send({OP_READ_SR2, 32'h0}, 16);
		check("sr2 invert", rx, {1'b0, inv, 6'h00});
		// Chip erase over every low code and both invert settings
		for (int c = 0; c < 16; c++) begin
			wsr(OP_WRITE_SR1, {3'b000, c[2:0], 2'b00}, 1);
			wsr(OP_WRITE_SR2, {1'b0, c[3], 6'h00}, 1);
			s0 = starts;
			send({OP_WRITE_ENABLE, 32'h0}, 8);
			send({c[0] ? OP_CHIP_ERASE_A : OP_CHIP_ERASE_B, 32'h0}, 8);
			acc = (c[2:0] == 0 && !c[3]) || (c[2:0] == 7 && c[3]);
			check("chip erase", starts - s0, acc);
			wait_idle();
		end
		// Lock modes
		wsr(OP_WRITE_SR2, 8'h00, 1);
		wsr(OP_WRITE_SR1, 8'h80, 1);
		wp_n = 1'b0;
		wsr(OP_WRITE_SR1, 8'h88, 0);
		check("hw protected", status.protect_field, 0);
		wp_n = 1'b1;
		wsr(OP_WRITE_SR1, 8'h88, 1);
		check("hw unprotected", status.protect_field, 2);
		wsr(OP_WRITE_SR2, 8'h01, 1);
		send({OP_READ_SR2, 32'h0}, 16);
		check("lock hi read", rx, 8'h01);
		wsr(OP_WRITE_SR1, 8'h00, 0);
		check("one time lock", status.lock_mode_lo, 1);
		rst();
		check("lock after reset", status.lock_mode_lo, 0);
		wsr(OP_WRITE_SR2, 8'h01, 1);
		wsr(OP_WRITE_SR1, 8'h04, 0);
		check("power lock", status.protect_field, 0);
		rst();
		check("power lock cleared", status.lock_mode_hi, 0);
		wp_n = 1'b0;
		wsr(OP_WRITE_SR1, 8'h04, 1);
		check("software mode", status.protect_field, 1);
		send({OP_READ_SR1, 32'h0}, 16);
		check("sr1 read", rx, 8'h04);
		// Third byte: only the drive field is writable
		wsr(OP_WRITE_SR3, 8'hFF, 1);
		check("drive write", status.drive_sel, 2'h3);
		send({OP_READ_SR3, 32'h0}, 16);
		check("sr3 spare bits", rx, 8'h60);
		// One-time bits stay set once written
		wsr(OP_WRITE_SR2, 8'h3A, 1);
		wsr(OP_WRITE_SR2, 8'h00, 1);
		send({OP_READ_SR2, 32'h0}, 16);
		check("one-time bits kept", rx, 8'h38);
		// Software reset needs the arming command first
		send({OP_WRITE_ENABLE, 32'h0}, 8);
		send({OP_RESET, 32'h0}, 8);
		check("reset unarmed", status.write_latch_flag, 1);
		send({OP_RESET_ENABLE, 32'h0}, 8);
		send({OP_RESET, 32'h0}, 8);
		check("software reset", status.write_latch_flag, 0);
		test_done();
	end
endmodule

`default_nettype wire
